// *** ssf_pkg.sv ***
package ssf_pkg;

  // ***************************************************************
  // Bus geometry
  // ***************************************************************
  localparam int          APB_AW          = 8;
  localparam int          APB_DW          = 32;
  localparam int          CLK_WORD_W      = 16;
  localparam int          CLK_WORDS       = 4;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0]  OFS_STATUS      = 8'h00;
  localparam logic [7:0]  OFS_CONTROL     = 8'h04;
  localparam logic [7:0]  OFS_CLK_DATA0   = 8'h08;
  localparam logic [7:0]  OFS_CLK_DATA1   = 8'h0C;
  localparam logic [7:0]  OFS_CLK_DATA2   = 8'h10;
  localparam logic [7:0]  OFS_CLK_DATA3   = 8'h14;
  localparam logic [7:0]  OFS_WDT_CAUSE   = 8'h18;
  localparam logic [7:0]  OFS_TEST_ERR0   = 8'h1C;
  localparam logic [7:0]  OFS_TEST_ERR1   = 8'h20;

  // ***************************************************************
  // Status field positions
  // ***************************************************************
  localparam int          ST_CONST_OFF    = 0;
  localparam int          ST_CONST_ON     = 1;
  localparam int          ST_FUSE         = 2;
  localparam int          ST_DROPOUT      = 3;
  localparam int          ST_BAT_LIVE     = 4;
  localparam int          ST_BAT_LATCH    = 5;
  localparam int          ST_SELF_DIAG    = 6;
  localparam int          ST_DIAG         = 7;
  localparam int          ST_CLK_ERR      = 8;
  localparam int          ST_WDT          = 9;
  localparam int          ST_READY_DONE   = 10;
  localparam int          ST_TEST_ACT     = 11;
  localparam int          ST_FSTOP        = 12;
  localparam int          ST_TEST_ERR     = 13;

  // ***************************************************************
  // Control field positions and reset value
  // ***************************************************************
  localparam int          CT_CLK_SET      = 0;
  localparam int          CT_CLK_READ     = 1;
  localparam int          CT_ERR_RELEASE  = 2;
  localparam int          CT_CTRL_READY   = 3;
  localparam int          CT_EXT_BAT      = 4;
  localparam int          CT_W            = 5;
  localparam logic [4:0]  CONTROL_RST     = 5'h00;
  localparam logic [15:0] WORD_RST        = 16'h0000;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          AC_DROP_MS      = 20;
  localparam int          DC_DROP_MS      = 10;
  localparam int          AC_DROP_CYC     = AC_DROP_MS * (CLK_HZ / 1000);
  localparam int          DC_DROP_CYC     = DC_DROP_MS * (CLK_HZ / 1000);
  localparam int          DROP_CNT_W      = 20;

  // ***************************************************************
  // Bus response states
  // ***************************************************************
  typedef enum logic [1:0] {
    SSF_IDLE = 2'b00,
    SSF_WAIT = 2'b11,
    SSF_DONE = 2'b01
  } ssf_bus_st_t;

endpackage : ssf_pkg

// *** ssf_rise_det.sv ***
`timescale 1ns/100ps
`default_nettype none

module ssf_rise_det #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Levels in, pulses out
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out
);

  // ***************************************************************
  // Per-bit off-to-on detection
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic prev_ff;
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          prev_ff <= 1'b0;
        end else begin
          prev_ff <= level_in[gi];
        end
      end
      assign rise_out[gi] = level_in[gi] & ~prev_ff;
    end
  endgenerate

endmodule : ssf_rise_det

`default_nettype wire

// *** ssf_dropout_det.sv ***
`timescale 1ns/100ps
`default_nettype none

module ssf_dropout_det #(
  parameter int AC_CYC = 500000,
  parameter int DC_CYC = 250000,
  parameter int CNT_W  = 20
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Supply monitor
  input  wire logic supply_ok,
  input  wire logic supply_is_dc,
  output logic      short_drop
);

  // ***************************************************************
  // Interruption length counter
  // ***************************************************************
  logic [CNT_W-1:0] low_cnt_ff;
  logic [CNT_W-1:0] limit;
  logic             was_low_ff;

  assign limit = supply_is_dc ? CNT_W'(DC_CYC) : CNT_W'(AC_CYC);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_cnt_ff <= '0;
      was_low_ff <= 1'b0;
    end else begin
      was_low_ff <= ~supply_ok;
      if (supply_ok) begin
        low_cnt_ff <= '0;
      end else if (low_cnt_ff != '1) begin
        low_cnt_ff <= low_cnt_ff + CNT_W'(1);
      end
    end
  end

  // Return of supply after a gap shorter than the limit
  assign short_drop = supply_ok & was_low_ff & (low_cnt_ff < limit);

endmodule : ssf_dropout_det

`default_nettype wire

// *** ssf_status_bank.sv ***
// Summary of operation
// - Latch fuse flag on any blown output module
// - AC supply: gap under 20ms sets dropout
// - DC supply: gap under 10ms sets dropout
// - Live battery flag follows battery, drives lamp
// - Latched battery flag holds after recovery
// - Battery checked only with external battery selected
// - Latch self-diagnostic error flag
// - Latch general diagnostic error flag
// - Set request rise loads clock element when all digits are valid BCD
// - Clock data error updated on set request
// - Read request held copies clock as BCD
// - Constant on and off flags
// - Error reset rise releases error flags
// - Watchdog error flag and cause word stored
// - Watchdog error stops all axes immediately
// - Ready rise checks parameters, sets complete
// - Ready off clears complete flag
// - Test mode flag; failed request flags error
// - Forced stop flag refreshed per operation cycle
// - Test request error stores two detail words
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module ssf_status_bank
  import ssf_pkg::*;
#(
  parameter int N_OUT_MOD   = 8,
  parameter int AC_DROP_LIM = ssf_pkg::AC_DROP_CYC,
  parameter int DC_DROP_LIM = ssf_pkg::DC_DROP_CYC
) (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           srst,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ssf_pkg::APB_AW-1:0]     paddr,
  input  wire logic [ssf_pkg::APB_DW-1:0]     pwdata,
  output logic      [ssf_pkg::APB_DW-1:0]     prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Supply and battery
  input  wire logic [N_OUT_MOD-1:0]           fuse_blown_in,
  input  wire logic                           supply_ok,
  input  wire logic                           supply_is_dc,
  input  wire logic                           battery_low_in,
  // Diagnosis
  input  wire logic                           self_diag_err_in,
  input  wire logic                           diag_err_in,
  input  wire logic                           wdt_err_in,
  input  wire logic [ssf_pkg::CLK_WORD_W-1:0] wdt_cause_in,
  input  wire logic                           param_check_err_in,
  // Test mode from peripheral device
  input  wire logic                           test_req_in,
  input  wire logic                           test_ok_in,
  input  wire logic                           test_exit_in,
  input  wire logic [ssf_pkg::CLK_WORD_W-1:0] test_err0_in,
  input  wire logic [ssf_pkg::CLK_WORD_W-1:0] test_err1_in,
  // Operation cycle
  input  wire logic                           op_cycle_tick,
  input  wire logic                           forced_stop_in,
  // Outputs to the system
  output logic                                battery_indicator_lamp,
  output logic                                axis_stop,
  output logic                                error_release_pulse
);

  import ssf_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  ssf_bus_st_t                         bus_st_ff;
  logic [APB_DW-1:0]                   prdata_ff;
  logic                                pslverr_ff;
  logic                                pready_ff;
  logic [CT_W-1:0]                     control_ff;
  logic [CLK_WORD_W-1:0]               clock_data_words [CLK_WORDS];
  logic [CLK_WORD_W-1:0]               calendar_ff [CLK_WORDS];
  logic [CLK_WORD_W-1:0]               watchdog_cause_word;
  logic [CLK_WORD_W-1:0]               test_mode_error_words [2];
  logic                                fuse_blown_flag;
  logic                                supply_dropout_flag;
  logic                                battery_low_live_flag;
  logic                                battery_low_latched_flag;
  logic                                self_diag_error_flag;
  logic                                diag_error_flag;
  logic                                clock_data_error_flag;
  logic                                proc_watchdog_error_flag;
  logic                                ready_complete_flag;
  logic                                test_mode_active_flag;
  logic                                forced_stop_input_flag;
  logic                                test_mode_request_error_flag;
  logic                                constant_on_flag;
  logic                                constant_off_flag;
  logic                                lamp_ff;
  logic                                axis_stop_ff;
  logic                                release_ff;
  logic                                wr_fire;
  logic                                rd_take;
  logic                                addr_ok;
  logic [APB_DW-1:0]                   rd_mux;
  logic [2:0]                          req_rise;
  logic                                clock_set_request;
  logic                                clock_read_request;
  logic                                error_release_request;
  logic                                controller_ready_input;
  logic                                set_rise;
  logic                                release_rise;
  logic                                ready_rise;
  logic                                short_drop;
  logic                                clk_data_valid;
  logic [CLK_WORDS*CLK_WORD_W-1:0]     clk_flat;
  logic [APB_DW-1:0]                   status_word;

  assign clock_set_request      = control_ff[CT_CLK_SET];
  assign clock_read_request     = control_ff[CT_CLK_READ];
  assign error_release_request  = control_ff[CT_ERR_RELEASE];
  assign controller_ready_input = control_ff[CT_CTRL_READY];

  // ***************************************************************
  // APB slave with one wait state
  // ***************************************************************
  assign wr_fire = psel & penable & pready & pwrite & addr_ok;
  assign rd_take = psel & penable & (bus_st_ff == SSF_IDLE);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_st_ff  <= SSF_IDLE;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
      pready_ff  <= 1'b0;
    end else begin
      case (bus_st_ff)
        SSF_IDLE: begin
          if (rd_take) begin
            bus_st_ff  <= SSF_DONE;
            prdata_ff  <= pwrite ? '0 : rd_mux;
            pslverr_ff <= ~addr_ok;
            pready_ff  <= 1'b1;
          end
        end
        SSF_DONE: begin
          bus_st_ff  <= SSF_IDLE;
          prdata_ff  <= '0;
          pslverr_ff <= 1'b0;
          pready_ff  <= 1'b0;
        end
        default: begin
          bus_st_ff <= SSF_IDLE;
          pready_ff <= 1'b0;
        end
      endcase
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // ***************************************************************
  // Address decode and read mux
  // ***************************************************************
  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = '0;
    case (paddr)
      OFS_STATUS:    rd_mux = status_word;
      OFS_CONTROL:   rd_mux = {{(APB_DW-CT_W){1'b0}}, control_ff};
      OFS_CLK_DATA0: rd_mux = {16'h0000, clock_data_words[0]};
      OFS_CLK_DATA1: rd_mux = {16'h0000, clock_data_words[1]};
      OFS_CLK_DATA2: rd_mux = {16'h0000, clock_data_words[2]};
      OFS_CLK_DATA3: rd_mux = {16'h0000, clock_data_words[3]};
      OFS_WDT_CAUSE: rd_mux = {16'h0000, watchdog_cause_word};
      OFS_TEST_ERR0: rd_mux = {16'h0000, test_mode_error_words[0]};
      OFS_TEST_ERR1: rd_mux = {16'h0000, test_mode_error_words[1]};
      default:       addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    status_word                = '0;
    status_word[ST_CONST_OFF]  = constant_off_flag;
    status_word[ST_CONST_ON]   = constant_on_flag;
    status_word[ST_FUSE]       = fuse_blown_flag;
    status_word[ST_DROPOUT]    = supply_dropout_flag;
    status_word[ST_BAT_LIVE]   = battery_low_live_flag;
    status_word[ST_BAT_LATCH]  = battery_low_latched_flag;
    status_word[ST_SELF_DIAG]  = self_diag_error_flag;
    status_word[ST_DIAG]       = diag_error_flag;
    status_word[ST_CLK_ERR]    = clock_data_error_flag;
    status_word[ST_WDT]        = proc_watchdog_error_flag;
    status_word[ST_READY_DONE] = ready_complete_flag;
    status_word[ST_TEST_ACT]   = test_mode_active_flag;
    status_word[ST_FSTOP]      = forced_stop_input_flag;
    status_word[ST_TEST_ERR]   = test_mode_request_error_flag;
  end

  // ***************************************************************
  // Control register
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      control_ff <= CONTROL_RST;
    end else if (wr_fire && paddr == OFS_CONTROL) begin
      control_ff <= pwdata[CT_W-1:0];
    end
  end

  // ***************************************************************
  // Request edge detection
  // ***************************************************************
  ssf_rise_det #(
    .WIDTH (3)
  ) u_req_rise (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .level_in ({controller_ready_input, error_release_request, clock_set_request}),
    .rise_out (req_rise)
  );

  assign set_rise     = req_rise[0];
  assign release_rise = req_rise[1];
  assign ready_rise   = req_rise[2];

  // ***************************************************************
  // Supply dropout detection
  // ***************************************************************
  ssf_dropout_det #(
    .AC_CYC (AC_DROP_LIM),
    .DC_CYC (DC_DROP_LIM),
    .CNT_W  (DROP_CNT_W)
  ) u_drop (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .supply_ok    (supply_ok),
    .supply_is_dc (supply_is_dc),
    .short_drop   (short_drop)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fuse_blown_flag     <= 1'b0;
      supply_dropout_flag <= 1'b0;
    end else begin
      if (|fuse_blown_in) begin
        fuse_blown_flag <= 1'b1;
      end
      if (short_drop) begin
        supply_dropout_flag <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Battery monitoring
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      battery_low_live_flag    <= 1'b0;
      battery_low_latched_flag <= 1'b0;
      lamp_ff                  <= 1'b0;
    end else if (control_ff[CT_EXT_BAT]) begin
      battery_low_live_flag <= battery_low_in;
      lamp_ff               <= battery_low_in;
      if (battery_low_in) begin
        battery_low_latched_flag <= 1'b1;
      end
    end
  end

  assign battery_indicator_lamp = lamp_ff;

  // ***************************************************************
  // Diagnostic error flags, error release
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      self_diag_error_flag     <= 1'b0;
      diag_error_flag          <= 1'b0;
      proc_watchdog_error_flag <= 1'b0;
      watchdog_cause_word      <= WORD_RST;
      release_ff               <= 1'b0;
    end else begin
      release_ff <= release_rise;
      if (self_diag_err_in) begin
        self_diag_error_flag <= 1'b1;
      end else if (release_rise) begin
        self_diag_error_flag <= 1'b0;
      end
      if (diag_err_in) begin
        diag_error_flag <= 1'b1;
      end else if (release_rise) begin
        diag_error_flag <= 1'b0;
      end
      if (wdt_err_in) begin
        proc_watchdog_error_flag <= 1'b1;
        watchdog_cause_word      <= wdt_cause_in;
      end else if (release_rise) begin
        proc_watchdog_error_flag <= 1'b0;
      end
    end
  end

  assign error_release_pulse = release_ff;

  // ***************************************************************
  // Immediate axis stop
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      axis_stop_ff <= 1'b0;
    end else begin
      axis_stop_ff <= wdt_err_in | proc_watchdog_error_flag;
    end
  end

  assign axis_stop = axis_stop_ff;

  // ***************************************************************
  // Clock data words and calendar element
  // ***************************************************************
  genvar gw;
  generate
    for (gw = 0; gw < CLK_WORDS; gw++) begin : g_clk
      assign clk_flat[gw*CLK_WORD_W +: CLK_WORD_W] = clock_data_words[gw];
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          clock_data_words[gw] <= WORD_RST;
          calendar_ff[gw]      <= WORD_RST;
        end else begin
          if (clock_read_request) begin
            clock_data_words[gw] <= calendar_ff[gw];
          end else if (wr_fire && paddr == OFS_CLK_DATA0 + 8'(4 * gw)) begin
            clock_data_words[gw] <= pwdata[CLK_WORD_W-1:0];
          end
          if (set_rise && clk_data_valid) begin
            calendar_ff[gw] <= clock_data_words[gw];
          end
        end
      end
    end
  endgenerate

  // All nibbles must be decimal digits
  always_comb begin
    clk_data_valid = 1'b1;
    for (int i = 0; i < CLK_WORDS * CLK_WORD_W / 4; i++) begin
      if (clk_flat[i*4 +: 4] > 4'h9) begin
        clk_data_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clock_data_error_flag <= 1'b0;
    end else if (set_rise) begin
      clock_data_error_flag <= ~clk_data_valid;
    end else if (release_rise) begin
      clock_data_error_flag <= 1'b0;
    end
  end

  // ***************************************************************
  // Constant flags
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      constant_on_flag  <= 1'b0;
      constant_off_flag <= 1'b0;
    end else begin
      constant_on_flag  <= 1'b1;
      constant_off_flag <= 1'b0;
    end
  end

  // ***************************************************************
  // Controller ready handshake
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ready_complete_flag <= 1'b0;
    end else if (!controller_ready_input) begin
      ready_complete_flag <= 1'b0;
    end else if (ready_rise && !param_check_err_in) begin
      ready_complete_flag <= 1'b1;
    end
  end

  // ***************************************************************
  // Test mode
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      test_mode_active_flag        <= 1'b0;
      test_mode_request_error_flag <= 1'b0;
      test_mode_error_words[0]     <= WORD_RST;
      test_mode_error_words[1]     <= WORD_RST;
    end else begin
      if (test_req_in && test_ok_in) begin
        test_mode_active_flag <= 1'b1;
      end else if (test_exit_in) begin
        test_mode_active_flag <= 1'b0;
      end
      if (test_req_in && !test_ok_in) begin
        test_mode_request_error_flag <= 1'b1;
        test_mode_error_words[0]     <= test_err0_in;
        test_mode_error_words[1]     <= test_err1_in;
      end else if (release_rise) begin
        test_mode_request_error_flag <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Forced stop sampling
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      forced_stop_input_flag <= 1'b0;
    end else if (op_cycle_tick) begin
      forced_stop_input_flag <= forced_stop_in;
    end
  end

endmodule : ssf_status_bank

`default_nettype wire

// *** ssf_status_bank_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssf_status_bank_properties (
  // Clock and bus
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ssf_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Watchdog and release
  input wire logic wdt_err_in,
  input wire logic axis_stop,
  input wire logic error_release_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_acc;
    psel && $rose(penable);
  endsequence
  a_one_wait: assert property (s_acc |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("prdata not zero");
  a_wdt_stop: assert property (wdt_err_in |=> axis_stop) else $error("no stop");
  a_stop_cause: assert property ($rose(axis_stop) |-> $past(wdt_err_in))
    else $error("stray stop");
  a_rel_pulse: assert property (error_release_pulse |=> !error_release_pulse)
    else $error("long pulse");
endmodule : ssf_status_bank_properties
bind ssf_status_bank ssf_status_bank_properties u_props (.sys_clk, .srst, .psel, .penable,
  .prdata, .pready, .pslverr, .wdt_err_in, .axis_stop, .error_release_pulse);
`default_nettype wire

// *** ssf_periph_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssf_periph_model (
  // Clock
  input wire logic   sys_clk,
  // Test mode lines
  output logic        test_req_in,
  output logic        test_ok_in,
  output logic        test_exit_in,
  output logic [15:0] test_err0_in,
  output logic [15:0] test_err1_in
);
  task automatic drv(input logic r, input logic ok, input logic [15:0] e);
    test_req_in <= r;
    test_ok_in <= ok;
    test_err0_in <= e;
    test_err1_in <= ~e;
  endtask : drv
  initial begin
    test_exit_in = 1'b0;
    drv(1'b0, 1'b0, 16'h0);
  end
  // One-cycle request; lines inverted once it is over
  task automatic req(input logic ok, input logic [15:0] e);
    drv(1'b1, ok, e);
    @(posedge sys_clk);
    drv(1'b0, ~ok, ~e);
    @(posedge sys_clk);
  endtask : req
  task automatic leave;
    test_exit_in <= 1'b1;
    @(posedge sys_clk);
    test_exit_in <= 1'b0;
    @(posedge sys_clk);
  endtask : leave
endmodule : ssf_periph_model
`default_nettype wire

// *** ssf_status_bank_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ssf_status_bank_bench;
  import ssf_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic supply_ok = 1'b1, supply_is_dc = 1'b1, battery_low_in = 1'b0, wdt_err_in = 1'b0;
  logic self_diag_err_in = 1'b0, diag_err_in = 1'b0, param_check_err_in = 1'b0;
  logic op_cycle_tick = 1'b0, forced_stop_in = 1'b0, test_req_in, test_ok_in, test_exit_in;
  logic pready, pslverr, battery_indicator_lamp, axis_stop, error_release_pulse, err;
  logic [7:0] paddr = 8'h0, fuse_blown_in = 8'h0;
  logic [15:0] wdt_cause_in = 16'h0, test_err0_in, test_err1_in;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int n_fail = 0, samples_checked = 0;
  ssf_status_bank #(.AC_DROP_LIM(40), .DC_DROP_LIM(20)) DUT (.*);
  ssf_periph_model pm (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", e, q & m);
  endtask : st
  task automatic cw(input logic [31:0] v);
    apb(1'b1, OFS_CONTROL, v);
  endtask : cw
  task automatic t_latch;
    fuse_blown_in <= 8'h80;
    self_diag_err_in <= 1'b1;
    diag_err_in <= 1'b1;
    @(posedge sys_clk);
    fuse_blown_in <= 8'h0;
    self_diag_err_in <= 1'b0;
    diag_err_in <= 1'b0;
    st(32'hC4, 32'hC4);
    cw(32'h4);
    @(negedge sys_clk) chk("release", 32'h1, {31'h0, error_release_pulse});
    @(posedge sys_clk);
    cw(32'h0);
    st(32'hC4, 32'h4);
  endtask : t_latch
  task automatic t_bat;
    battery_low_in <= 1'b1;
    st(32'h30, 32'h0);
    cw(32'h10);
    st(32'h30, 32'h30);
    chk("lamp", 32'h1, {31'h0, battery_indicator_lamp});
    battery_low_in <= 1'b0;
    st(32'h30, 32'h20);
  endtask : t_bat
  task automatic t_clk;
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(OFS_CLK_DATA0 + 4 * i), 32'(17 * (i + 1)));
    cw(32'h1);
    st(32'h100, 32'h0);
    apb(1'b1, OFS_CLK_DATA0, 32'hAB);
    cw(32'h0);
    cw(32'h1);
    st(32'h100, 32'h100);
    cw(32'h2);
    apb(1'b0, OFS_CLK_DATA0, 32'h0);
    chk("clock word", 32'h11, q);
  endtask : t_clk
  task automatic t_wdt;
    wdt_cause_in <= 16'h5A3C;
    wdt_err_in <= 1'b1;
    forced_stop_in <= 1'b1;
    @(posedge sys_clk);
    wdt_cause_in <= 16'hA5C3;
    wdt_err_in <= 1'b0;
    @(posedge sys_clk);
    chk("axis stop", 32'h1, {31'h0, axis_stop});
    apb(1'b0, OFS_WDT_CAUSE, 32'h0);
    chk("cause", 32'h5A3C, q);
    st(32'h1200, 32'h200);
    op_cycle_tick <= 1'b1;
    @(posedge sys_clk);
    op_cycle_tick <= 1'b0;
    st(32'h1000, 32'h1000);
  endtask : t_wdt
  task automatic t_ready;
    param_check_err_in <= 1'b1;
    cw(32'h8);
    st(32'h400, 32'h0);
    cw(32'h0);
    param_check_err_in <= 1'b0;
    cw(32'h8);
    st(32'h400, 32'h400);
    cw(32'h0);
    st(32'h400, 32'h0);
  endtask : t_ready
  task automatic t_test;
    pm.req(1'b0, 16'h1357);
    st(32'h2800, 32'h2000);
    apb(1'b0, OFS_TEST_ERR1, 32'h0);
    chk("test err", 32'hECA8, q);
    pm.req(1'b1, 16'h0);
    st(32'h2800, 32'h2800);
    pm.leave();
    st(32'h800, 32'h0);
  endtask : t_test
  task automatic gap(input logic dc, input int n, input logic [31:0] e);
    supply_is_dc <= dc;
    supply_ok <= 1'b0;
    repeat (n) @(posedge sys_clk);
    supply_ok <= 1'b1;
    st(32'h8, e);
  endtask : gap
  task automatic t_drop;
    gap(1'b1, 10, 32'h8);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    gap(1'b1, 30, 32'h0);
    gap(1'b0, 30, 32'h8);
  endtask : t_drop
  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    st(32'hFFFF, 32'h2);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    t_latch();
    t_bat();
    t_clk();
    t_wdt();
    t_ready();
    t_test();
    t_drop();
    results();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    results();
  end
endmodule : ssf_status_bank_bench
`default_nettype wire
